// ===== bmsl_pkg.sv
package bmsl_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned WORD_W = 24;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned EXT_AW = 18;
    localparam int unsigned BYTES_PER_WORD = 3;

    // ==========================================================
    // Addresses and access timing
    localparam logic [23:0] FETCH_MODE0        = 24'hC00000;
    localparam logic [23:0] FETCH_MODE8        = 24'h008000;
    localparam logic [23:0] BOOT_VECTOR        = 24'hFF0000;
    localparam logic [23:0] BYTE_MEM_BASE      = 24'hD00000;
    localparam logic [23:0] PROM_START_DEFAULT = 24'h000000;
    localparam logic [4:0]  WAIT_STATES        = 5'h1F;

    // ==========================================================
    // Mode numbers
    localparam logic [3:0] MODE_EXP_LOW  = 4'h0;
    localparam logic [3:0] MODE_BYTE_MEM = 4'h1;
    localparam logic [3:0] MODE_PROM     = 4'h2;
    localparam logic [3:0] MODE_SPI      = 4'h5;
    localparam logic [3:0] MODE_I2C_FLT  = 4'h6;
    localparam logic [3:0] MODE_I2C      = 4'h7;
    localparam logic [3:0] MODE_EXP_HIGH = 4'h8;
    localparam logic [3:0] MODE_BURN_IN  = 4'h9;

    typedef enum logic [1:0] {
        BUS_ISA,
        BUS_NONMUX,
        BUS_MUX,
        BUS_MICRO
    } bmsl_bus_type;

    // ==========================================================
    // Mode decoding
    function automatic logic is_host_mode(input logic [3:0] m);
        return m[3] & m[2];
    endfunction

    function automatic logic is_serial_mode(input logic [3:0] m);
        return (m == MODE_SPI) || (m == MODE_I2C_FLT) || (m == MODE_I2C);
    endfunction

    function automatic logic is_reserved_mode(input logic [3:0] m);
        return (m == 4'h3) || (m == 4'h4) || (m == 4'hA) || (m == 4'hB)
            || (m == MODE_BURN_IN);
    endfunction

endpackage

// ===== bmsl_word_if.sv
`timescale 1ns/1ns
`default_nettype none

interface bmsl_word_if;
    logic        enable;
    logic        ready;
    logic        valid;
    logic [23:0] word;

    modport loader (output enable, output ready, input valid, input word);
    modport reader (input enable, input ready, output valid, output word);
endinterface

`default_nettype wire

// ===== bmsl_byte_reader.sv
`timescale 1ns/1ns
`default_nettype none

module bmsl_byte_reader
    import bmsl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    bmsl_word_if.reader     bus,
    output logic [17:0]     ext_addr,
    output logic            ext_rd_en,
    input  wire logic [7:0] ext_data
);

    // ==========================================================
    // Byte access timing
    logic [4:0]  wait_q;
    logic [1:0]  idx_q;
    logic [23:0] offs_q;
    logic [23:0] word_q;
    logic        valid_q;

    assign bus.valid = valid_q;
    assign bus.word  = word_q;
    // Low offset only: the base reads as zero on the pins
    assign ext_addr  = offs_q[17:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_q    <= 5'h00;
            idx_q     <= 2'h0;
            offs_q    <= 24'h000000;
            ext_rd_en <= 1'b0;
        end else if (ext_rd_en) begin
            // Each read lasts one cycle plus the wait states
            if (wait_q == WAIT_STATES) begin
                wait_q <= 5'h00;
                offs_q <= offs_q + 24'h000001;
                if (idx_q == 2'(BYTES_PER_WORD - 1)) begin
                    idx_q     <= 2'h0;
                    ext_rd_en <= 1'b0;
                end else begin
                    idx_q <= idx_q + 2'h1;
                end
            end else begin
                wait_q <= wait_q + 5'h01;
            end
        end else if (bus.enable && !valid_q) begin
            ext_rd_en <= 1'b1;
        end
    end

    // ==========================================================
    // Word assembly, low byte first
    always_ff @(posedge mclk) begin
        if (rst) begin
            word_q  <= 24'h000000;
            valid_q <= 1'b0;
        end else if (ext_rd_en && wait_q == WAIT_STATES) begin
            word_q <= {ext_data, word_q[23:8]};
            if (idx_q == 2'(BYTES_PER_WORD - 1)) begin
                valid_q <= 1'b1;
            end
        end else if (valid_q && bus.ready) begin
            valid_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== bmsl_top.sv
`timescale 1ns/1ns
`default_nettype none

module bmsl_top #(
    parameter logic [23:0] PROM_START = bmsl_pkg::PROM_START_DEFAULT
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 mode_pin_a,
    input  wire logic                 mode_pin_b,
    input  wire logic                 mode_pin_c,
    input  wire logic                 mode_pin_d,
    output logic [17:0]               ext_addr,
    output logic                      ext_rd_en,
    input  wire logic [7:0]           ext_data,
    output logic [4:0]                ext_wait_states,
    output logic                      ext_attr_en,
    output logic                      aar_one_select,
    input  wire logic [23:0]          ser_word,
    input  wire logic                 ser_valid,
    output logic                      ser_ready,
    input  wire logic [23:0]          host_word,
    input  wire logic                 host_valid,
    output logic                      host_ready,
    input  wire logic                 host_flag_zero,
    output logic                      program_ram_we,
    output logic [23:0]               program_ram_addr,
    output logic [23:0]               program_ram_data,
    output logic                      core_run,
    output logic                      core_start,
    output logic [23:0]               core_pc,
    output logic [23:0]               reset_vector,
    output logic                      boot_rom_active,
    output logic [3:0]                boot_mode,
    output logic                      mode_reserved,
    output logic                      burn_in_mode,
    output logic                      serial_port_enable,
    output logic                      serial_i2c_mode,
    output logic                      i2c_fast_filter_select,
    output logic                      i2c_filter_enable,
    output logic                      parallel_port_enable,
    output bmsl_pkg::bmsl_bus_type    host_bus_style,
    output logic                      load_busy,
    output logic [23:0]               words_loaded,
    output logic                      early_end
);
    import bmsl_pkg::*;

    // ==========================================================
    // Declarations
    typedef enum logic [2:0] {
        ST_LATCH,
        ST_DISPATCH,
        ST_COUNT,
        ST_ADDR,
        ST_LOAD,
        ST_RUN,
        ST_HALT
    } bmsl_state_type;

    bmsl_state_type state_q;
    logic [3:0]     mode_q;
    logic [23:0]    count_q;
    logic [23:0]    remain_q;
    logic [23:0]    load_addr_q;
    logic [23:0]    ptr_q;
    logic [23:0]    loaded_q;
    logic           early_q;
    logic           start_q;
    logic           run_q;
    logic [23:0]    pc_q;
    logic           we_q;
    logic [23:0]    waddr_q;
    logic [23:0]    wdata_q;

    logic           src_valid;
    logic [23:0]    src_word;
    logic           accepting;
    logic           take;
    logic           host_stop;

    bmsl_word_if byte_bus ();

    // ==========================================================
    // Byte-wide memory reader
    bmsl_byte_reader u_reader (
        .mclk      (mclk),
        .rst       (rst),
        .bus       (byte_bus),
        .ext_addr  (ext_addr),
        .ext_rd_en (ext_rd_en),
        .ext_data  (ext_data)
    );

    // ==========================================================
    // Mode latch
    // Pins are only looked at while reset is high
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_q <= {mode_pin_d, mode_pin_c, mode_pin_b, mode_pin_a};
        end else begin
            mode_q <= mode_q;
        end
    end

    assign boot_mode = mode_q;

    // ==========================================================
    // Word source selection
    assign accepting = (state_q == ST_COUNT) || (state_q == ST_ADDR)
                    || (state_q == ST_LOAD);
    // In the load state a raised host flag wins over a word in the same cycle
    assign host_stop = is_host_mode(mode_q) && host_flag_zero
                    && (state_q == ST_LOAD);

    always_comb begin
        src_valid = 1'b0;
        src_word  = 24'h000000;
        if (mode_q == MODE_BYTE_MEM) begin
            src_valid = byte_bus.valid;
            src_word  = byte_bus.word;
        end else if (is_serial_mode(mode_q)) begin
            src_valid = ser_valid;
            src_word  = ser_word;
        end else if (is_host_mode(mode_q)) begin
            src_valid = host_valid;
            src_word  = host_word;
        end
    end

    assign byte_bus.enable = accepting && (mode_q == MODE_BYTE_MEM);
    assign byte_bus.ready  = accepting;
    assign ser_ready  = accepting && is_serial_mode(mode_q);
    assign host_ready = accepting && is_host_mode(mode_q) && !host_stop;
    assign take       = accepting && src_valid && !host_stop;

    // ==========================================================
    // Boot sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_LATCH;
        end else begin
            unique case (state_q)
                ST_LATCH: begin
                    state_q <= ST_DISPATCH;
                end
                ST_DISPATCH: begin
                    if (is_reserved_mode(mode_q)) begin
                        state_q <= ST_HALT;
                    end else if (mode_q == MODE_EXP_LOW
                              || mode_q == MODE_EXP_HIGH
                              || mode_q == MODE_PROM) begin
                        state_q <= ST_RUN;
                    end else begin
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (take) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (take) begin
                        // An empty image runs straight away
                        state_q <= (count_q == 24'h000000) ? ST_RUN : ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (host_stop) begin
                        state_q <= ST_RUN;
                    end else if (take && remain_q == 24'h000001) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
                ST_HALT: begin
                    state_q <= ST_HALT;
                end
            endcase
        end
    end

    // ==========================================================
    // Header words and load pointer
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_q     <= 24'h000000;
            remain_q    <= 24'h000000;
            load_addr_q <= 24'h000000;
            ptr_q       <= 24'h000000;
        end else if (take) begin
            if (state_q == ST_COUNT) begin
                count_q  <= src_word;
                remain_q <= src_word;
            end else if (state_q == ST_ADDR) begin
                load_addr_q <= src_word;
                ptr_q       <= src_word;
            end else begin
                ptr_q    <= ptr_q + 24'h000001;
                remain_q <= remain_q - 24'h000001;
            end
        end
    end

    // ==========================================================
    // Program RAM write port
    always_ff @(posedge mclk) begin
        if (rst) begin
            we_q    <= 1'b0;
            waddr_q <= 24'h000000;
            wdata_q <= 24'h000000;
        end else begin
            we_q <= take && (state_q == ST_LOAD);
            if (take && state_q == ST_LOAD) begin
                waddr_q <= ptr_q;
                wdata_q <= src_word;
            end
        end
    end

    assign program_ram_we   = we_q;
    assign program_ram_addr = waddr_q;
    assign program_ram_data = wdata_q;

    // ==========================================================
    // Load statistics
    always_ff @(posedge mclk) begin
        if (rst) begin
            loaded_q <= 24'h000000;
            early_q  <= 1'b0;
        end else begin
            if (take && state_q == ST_LOAD) begin
                loaded_q <= loaded_q + 24'h000001;
            end
            if (host_stop) begin
                early_q <= 1'b1;
            end
        end
    end

    assign words_loaded = loaded_q;
    assign early_end    = early_q;
    assign load_busy    = accepting;

    // ==========================================================
    // Execution start
    // The start pulse is issued once, one cycle after entry to the run state
    always_ff @(posedge mclk) begin
        if (rst) begin
            run_q   <= 1'b0;
            start_q <= 1'b0;
            pc_q    <= 24'h000000;
        end else begin
            start_q <= 1'b0;
            if (!run_q && state_q == ST_RUN) begin
                run_q   <= 1'b1;
                start_q <= 1'b1;
                if (mode_q == MODE_EXP_LOW) begin
                    pc_q <= FETCH_MODE0;
                end else if (mode_q == MODE_EXP_HIGH) begin
                    pc_q <= FETCH_MODE8;
                end else if (mode_q == MODE_PROM) begin
                    pc_q <= PROM_START;
                end else begin
                    pc_q <= load_addr_q;
                end
            end
        end
    end

    assign core_run   = run_q;
    assign core_start = start_q;
    assign core_pc    = pc_q;

    // ==========================================================
    // Mode dependent configuration
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_vector           <= BOOT_VECTOR;
            boot_rom_active        <= 1'b0;
            ext_wait_states        <= WAIT_STATES;
            ext_attr_en            <= 1'b0;
            aar_one_select         <= 1'b0;
            mode_reserved          <= 1'b0;
            burn_in_mode           <= 1'b0;
            serial_port_enable     <= 1'b0;
            serial_i2c_mode        <= 1'b0;
            i2c_fast_filter_select <= 1'b0;
            i2c_filter_enable      <= 1'b0;
            parallel_port_enable   <= 1'b0;
            host_bus_style         <= BUS_ISA;
        end else begin
            if (mode_q == MODE_EXP_LOW) begin
                reset_vector <= FETCH_MODE0;
            end else if (mode_q == MODE_EXP_HIGH) begin
                reset_vector <= FETCH_MODE8;
            end else begin
                reset_vector <= BOOT_VECTOR;
            end
            boot_rom_active <= (mode_q != MODE_EXP_LOW)
                            && (mode_q != MODE_EXP_HIGH);
            // All boot fetches use plain SRAM timing
            ext_wait_states <= WAIT_STATES;
            ext_attr_en     <= 1'b0;
            aar_one_select  <= (mode_q == MODE_BYTE_MEM);
            mode_reserved   <= is_reserved_mode(mode_q);
            burn_in_mode    <= (mode_q == MODE_BURN_IN);
            serial_port_enable <= is_serial_mode(mode_q);
            serial_i2c_mode    <= (mode_q == MODE_I2C_FLT)
                               || (mode_q == MODE_I2C);
            i2c_fast_filter_select <= (mode_q == MODE_I2C_FLT);
            i2c_filter_enable      <= (mode_q == MODE_I2C_FLT);
            parallel_port_enable   <= is_host_mode(mode_q);
            // Bus style follows the two low mode bits; C is ISA
            host_bus_style <= bmsl_bus_type'(mode_q[1:0]);
            if (mode_q == MODE_I2C) begin
                i2c_fast_filter_select <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ===== bmsl_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================
// Port checks for the boot loader
module bmsl_top_props
    import bmsl_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [4:0]  ext_wait_states,
    input wire logic        ext_attr_en,
    input wire logic        ext_rd_en,
    input wire logic        aar_one_select,
    input wire logic        program_ram_we,
    input wire logic [23:0] program_ram_addr,
    input wire logic        core_run,
    input wire logic        core_start,
    input wire logic [23:0] core_pc,
    input wire logic [23:0] reset_vector,
    input wire logic        boot_rom_active,
    input wire logic        serial_port_enable,
    input wire logic        serial_i2c_mode,
    input wire logic        i2c_fast_filter_select,
    input wire logic        i2c_filter_enable,
    input wire logic        parallel_port_enable,
    input wire logic        early_end
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_wait_fixed: assert property (
        ext_wait_states == WAIT_STATES && !ext_attr_en)
        else $error("wait states or attributes wrong");
    a_start_pulse: assert property (
        core_start |-> core_run ##1 !core_start)
        else $error("start pulse wrong");
    a_run_holds: assert property (
        core_run |=> core_run && $stable(core_pc))
        else $error("run state or start address moved");
    a_vector_map: assert property (
        boot_rom_active |-> reset_vector == BOOT_VECTOR)
        else $error("bootstrap vector wrong");
    a_expand_pc: assert property (
        core_start && !boot_rom_active |-> core_pc == reset_vector)
        else $error("expanded fetch address wrong");
    a_i2c_filter: assert property (
        i2c_fast_filter_select |-> i2c_filter_enable && serial_i2c_mode
            && serial_port_enable)
        else $error("filter select outside I2C load");
    a_write_step: assert property (
        program_ram_we ##1 program_ram_we |-> program_ram_addr == $past(program_ram_addr) + 24'h000001)
        else $error("program RAM address not consecutive");
    a_byte_attr: assert property (
        ext_rd_en |-> aar_one_select && !parallel_port_enable
            && !serial_port_enable)
        else $error("byte read without attribute select");
    a_early_run: assert property (
        $rose(early_end) |-> ##[0:3] core_run)
        else $error("early end did not start the core");
    a_mode_hold: assert property (
        !$past(rst) && !$past(rst, 2) |-> $stable(serial_port_enable)
            && $stable(parallel_port_enable) && $stable(boot_rom_active))
        else $error("latched mode changed after reset");
endmodule
`default_nettype wire

// ===== bmsl_byte_mem.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================
// Byte-wide boot memory: count 2, load 000340
module bmsl_byte_mem (
    input  wire logic        mclk,
    input  wire logic [17:0] ext_addr,
    input  wire logic        ext_rd_en,
    output logic [7:0]       ext_data
);
    // Each value low byte first, so byte i is just slice i
    localparam logic [95:0] IMG = 96'h0D0E0F_A1B2C3_000340_000002;
    logic [7:0] last_q = 8'h00;

    always_ff @(posedge mclk) begin
        if (ext_rd_en) begin
            last_q <= ext_data;
        end
    end
    // Idle bus shows the inverse so stale data never looks valid
    assign ext_data = (ext_rd_en && ext_addr < 18'h0000C) ?
        IMG[8 * ext_addr[3:0] +: 8] : ~last_q;
endmodule
`default_nettype wire

// ===== bmsl_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================
// Boot loader bench
module bmsl_top_tb;
    import bmsl_pkg::*;
    localparam logic [23:0] ROM_BASE = 24'h000400;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  pins = 4'h0;
    logic [23:0] ser_word = 24'h000000;
    logic [23:0] host_word = 24'h000000;
    logic        ser_valid = 1'b0;
    logic        host_valid = 1'b0;
    logic        host_flag_zero = 1'b0;
    wire  [7:0]  ext_data;
    logic [17:0] ext_addr;
    logic [23:0] program_ram_addr, program_ram_data, core_pc, reset_vector, words_loaded;
    logic        ext_rd_en, aar_one_select, ser_ready, host_ready, program_ram_we;
    logic        core_run, core_start, boot_rom_active, mode_reserved;
    logic        burn_in_mode, serial_port_enable, serial_i2c_mode;
    logic        i2c_fast_filter_select, i2c_filter_enable, early_end;
    logic        parallel_port_enable;
    logic        load_busy;
    logic [3:0]  boot_mode;
    bmsl_bus_type host_bus_style;
    logic [23:0] exp_base;
    logic [23:0] exp_w [0:3];
    int          wr_n = 0;
    int          fail_count = 0;
    int          checks_done = 0;

    bmsl_top #(.PROM_START(ROM_BASE)) i_dut (
        .mclk, .rst, .mode_pin_a(pins[0]), .mode_pin_b(pins[1]),
        .mode_pin_c(pins[2]), .mode_pin_d(pins[3]), .ext_addr,
        .ext_rd_en, .ext_data, .ext_wait_states(), .ext_attr_en(),
        .aar_one_select, .ser_word, .ser_valid, .ser_ready, .host_word,
        .host_valid, .host_ready, .host_flag_zero, .program_ram_we, .program_ram_addr,
        .program_ram_data, .core_run, .core_start, .core_pc, .reset_vector,
        .boot_rom_active, .boot_mode, .mode_reserved, .burn_in_mode,
        .serial_port_enable, .serial_i2c_mode, .i2c_fast_filter_select,
        .i2c_filter_enable, .parallel_port_enable, .host_bus_style,
        .load_busy, .words_loaded, .early_end
    );
    bmsl_byte_mem i_mem (.mclk, .ext_addr, .ext_rd_en, .ext_data);

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Every program RAM write is judged as it happens
    always @(posedge mclk) begin
        if (rst === 1'b1) begin
            wr_n = 0;
        end else if (program_ram_we === 1'b1) begin
            chk(program_ram_addr, exp_base + 24'(wr_n));
            chk(program_ram_data, exp_w[wr_n[1:0]]);
            wr_n++;
        end
    end

    task automatic start_mode(input logic [3:0] m);
        @(posedge mclk);
        rst <= 1'b1;
        pins <= m;
        host_flag_zero <= 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        pins <= ~m;
    endtask

    task automatic wait_start(input logic [23:0] pc);
        int n;
        n = 0;
        while (core_start !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
        chk({23'h0, core_start}, 24'h000001);
        chk(core_pc, pc);
    endtask

    // Holds the word until the edge where ready is seen high
    task automatic send(input logic [23:0] w, input logic h);
        int n;
        n = 0;
        if (h) begin
            host_word <= w;
            host_valid <= 1'b1;
        end else begin
            ser_word <= w;
            ser_valid <= 1'b1;
        end
        do begin
            @(posedge mclk);
            n++;
        end while ((h ? host_ready : ser_ready) !== 1'b1 && n < 100);
        chk({23'h0, n < 100}, 24'h000001);
    endtask

    task automatic t_modes;
        logic [3:0] m;
        logic       r;
        logic       hm;
        logic       ld;
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            r = m inside {4'h3, 4'h4, 4'h9, 4'hA, 4'hB};
            hm = m[3] & m[2];
            ld = m inside {4'h1, [4'h5:4'h7], [4'hC:4'hF]};
            start_mode(m);
            if (m == 4'h0) wait_start(FETCH_MODE0);
            if (m == 4'h8) wait_start(FETCH_MODE8);
            if (m == 4'h2) wait_start(ROM_BASE);
            repeat (3) @(posedge mclk);
            // Pins were inverted after release, so this also shows the hold
            chk({19'h0, load_busy, boot_mode},
                {19'h0, ld, m});
            chk({18'h0, mode_reserved, burn_in_mode, serial_port_enable,
                serial_i2c_mode, i2c_fast_filter_select, i2c_filter_enable},
                {18'h0, r, m == 4'h9, m inside {[4'h5:4'h7]},
                m inside {4'h6, 4'h7}, m == 4'h6, m == 4'h6});
            chk({21'h0, parallel_port_enable, hm ? 2'(host_bus_style) : 2'h0},
                {21'h0, hm, hm ? m[1:0] : 2'h0});
            chk(reset_vector, m == 4'h0 ? FETCH_MODE0 :
                m == 4'h8 ? FETCH_MODE8 : BOOT_VECTOR);
            chk({23'h0, boot_rom_active},
                {23'h0, m != 4'h0 && m != 4'h8});
            if (r) begin
                repeat (20) @(posedge mclk);
                chk({23'h0, core_run}, 24'h000000);
            end
        end
        $display("test modes done");
    endtask

    task automatic load(input logic [3:0] m, input logic h, input int stop);
        logic [23:0] a;
        a = 24'h000200 | {20'h0, m};
        start_mode(m);
        exp_base = a;
        for (int i = 0; i < 4; i++) exp_w[i] = {m, 4'hA, 8'(i), 8'hC5};
        send(24'h000003, h);
        send(a, h);
        for (int i = 0; i < stop; i++) send(exp_w[i], h);
        ser_valid <= 1'b0;
        host_valid <= 1'b0;
        if (stop < 3) host_flag_zero <= 1'b1;
        wait_start(a);
        chk(24'(wr_n), 24'(stop));
        chk(words_loaded, 24'(stop));
        chk({23'h0, early_end}, {23'h0, stop < 3});
        chk({23'h0, load_busy}, 24'h000000);
        $display("test load mode %h done", m);
    endtask

    task automatic t_byte;
        start_mode(4'h1);
        exp_base = 24'h000340;
        exp_w[0] = 24'hA1B2C3;
        exp_w[1] = 24'h0D0E0F;
        wait_start(24'h000340);
        chk(24'(wr_n), 24'h000002);
        chk({23'h0, aar_one_select}, 24'h000001);
        $display("test byte memory done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Whole run needs under a thousand cycles; this is ample
    initial begin
        #200000;
        fail_count++;
        finish_test;
    end

    initial begin
        t_modes;
        for (int i = 5; i < 8; i++) load(4'(i), 1'b0, 3);
        for (int i = 12; i < 16; i++) begin
            load(4'(i), 1'b1, i == 15 ? 1 : 3);
        end
        t_byte;
        finish_test;
    end
endmodule

bind bmsl_top bmsl_top_props u_props (
    .mclk, .rst, .ext_wait_states, .ext_attr_en, .ext_rd_en,
    .aar_one_select, .program_ram_we, .program_ram_addr, .core_run, .core_start,
    .core_pc, .reset_vector, .boot_rom_active, .serial_port_enable,
    .serial_i2c_mode, .i2c_fast_filter_select, .i2c_filter_enable,
    .parallel_port_enable, .early_end
);
`default_nettype wire
